// ==== shared/sers_pkg.sv ====
// constants and types for the serial eeprom reset and default-state block
// ============================================================================
// Contract
// R1: while power-on reset holds, ignore instructions; afterwards sit in standby
// R2: host waits at least the power-up time before the first instruction
// R3: chip select high-low-high with no clocks resets the interface to opcode wait
// R4: after power-up stay deselected; go active only on a chip select fall
// R5: write enable latch is zero after power-up
// R6: ready/busy flag reads zero after power-up
// R7: no paused condition after power-up
// R8: protect pin enable and block protect bits survive power cycles
// R9: factory state: array bytes all ones, protection bits all zero
// R10: selected only while chip select low; otherwise ignore input, output off
// R11: status byte: bit7 protect enable, bits 3:2 block protect, bit1 latch, bit0 busy
// R12: any reset drops partial bits and returns to opcode wait
package sers_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned PUP_WAIT_US   = 100;
  localparam int unsigned PUP_WAIT_CYC  =
    (PUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // status byte layout
  localparam int unsigned STAT_PPE = 7;
  localparam int unsigned STAT_BPH = 3;
  localparam int unsigned STAT_BPL = 2;
  localparam int unsigned STAT_WEL = 1;
  localparam int unsigned STAT_RDY = 0;
  localparam logic [7:0]  STAT_RST = 8'h00;

  // ==========================================================================
  // opcodes, bit 3 is a don't-care
  localparam logic [7:0] OP_MASK = 8'hf7;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;

  // ==========================================================================
  // factory contents and link counters
  localparam logic [2:0] NV_FACTORY  = 3'h0;
  localparam logic [7:0] ARR_FACTORY = 8'hff;
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [2:0] BIT_RST     = 3'h0;

  typedef enum logic [1:0] {
    ST_POR  = 2'b00,
    ST_STBY = 2'b01,
    ST_OPC  = 2'b10,
    ST_DATA = 2'b11
  } sers_state_type;

  function automatic logic op_match(input logic [7:0] b, input logic [7:0] op);
    return (b & OP_MASK) == op;
  endfunction

endpackage

// ==== verilog/sers_sync.sv ====
// two-flop level synchroniser
module sers_sync #(
  parameter int unsigned W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ==========================================================================
  // first stage feeds the second only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// ==== verilog/sers_nvstore.sv ====
// nonvolatile protection bits and array image
module sers_nvstore #(
  parameter int unsigned AW = 4
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          factory_init,
  input  wire logic          we,
  input  wire logic [2:0]    wdata,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [2:0]    nv_bits,
  output logic      [7:0]    rd_data
);

  logic [7:0] arr_q [2**AW];

  // ==========================================================================
  // storage, deliberately without reset: it must outlive power cycles
  always_ff @(posedge clk) begin
    if (factory_init) begin
      nv_bits <= sers_pkg::NV_FACTORY; // R9
    end else if (we) begin
      nv_bits <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < 2**AW; i++) begin
      if (factory_init) begin
        arr_q[i] <= sers_pkg::ARR_FACTORY; // R9
      end
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= arr_q[rd_addr];
  end

  // ==========================================================================
  // checks
  property p_factory;
    @(posedge clk) disable iff (!rstn)
    factory_init |=> nv_bits == sers_pkg::NV_FACTORY ##1 rd_data == sers_pkg::ARR_FACTORY;
  endproperty
  a_factory: assert property (p_factory) else $error("factory image wrong"); // R9

endmodule

// ==== verilog/sers_top.sv ====
// spi eeprom interface: power-up sequencing, cs reset, status defaults
module sers_top #(
  parameter int unsigned PUP_CYCLES = sers_pkg::PUP_WAIT_CYC,
  parameter int unsigned CNT_W      = 16,
  parameter int unsigned AW         = 4
) (
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic          sck,
  input  wire logic          cs_n,
  input  wire logic          si,
  input  wire logic          hold_n,
  output logic               so,
  output logic               so_oe,
  input  wire logic          factory_init,
  input  wire logic [AW-1:0] arr_addr,
  output logic      [7:0]    arr_rdata,
  output logic               ready_q,
  output logic               selected_q,
  output logic      [7:0]    status_q,
  output logic      [7:0]    opcode_q,
  output logic               opcode_stb_q
);

  localparam logic [CNT_W-1:0] PUP_LAST = CNT_W'(PUP_CYCLES - 1);

  // ==========================================================================
  // declarations
  sers_pkg::sers_state_type state_q;
  logic [CNT_W-1:0] pup_cnt_q;
  logic             cs_s;
  logic             cs_prev_q;
  logic             fall;
  logic             tog_s;
  logic             tog_prev_q;
  logic             byte_evt;
  logic             wel_q;
  logic             wrsr_q;
  logic             nv_we_q;
  logic [2:0]       nv_wdata_q;
  logic [2:0]       nv_bits;
  logic [8:0]       to_link;
  logic [8:0]       link_s;
  logic             link_rst_n;
  logic [2:0]       bit_q;
  logic [6:0]       sh_q;
  logic [7:0]       rx_byte;
  logic             first_q;
  logic             rd_q;
  logic             loaded_q;
  logic             hold_q;
  logic [7:0]       rot_q;
  logic [7:0]       byte_q;
  logic             tog_q;
  logic             bit_done;

  // ==========================================================================
  // power-up wait in the core domain
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pup_cnt_q <= '0;
      ready_q   <= 1'b0;
    end else if (!ready_q) begin
      if (pup_cnt_q == PUP_LAST) begin
        ready_q <= 1'b1; // R1
      end
      pup_cnt_q <= pup_cnt_q + CNT_W'(1);
    end
  end

  // ==========================================================================
  // crossings into the core domain
  sers_sync #(.W(1), .INIT(1'b1)) u_cs_sync (
    .clk   (ref_clk),
    .rst_n (rstn),
    .d     (cs_n),
    .q     (cs_s)
  );

  sers_sync #(.W(1), .INIT(1'b0)) u_tog_sync (
    .clk   (ref_clk),
    .rst_n (rstn),
    .d     (tog_q),
    .q     (tog_s)
  );

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cs_prev_q  <= 1'b1;
      tog_prev_q <= 1'b0;
    end else begin
      cs_prev_q  <= cs_s;
      tog_prev_q <= tog_s;
    end
  end

  assign fall     = cs_prev_q & ~cs_s;
  assign byte_evt = tog_s ^ tog_prev_q;

  // ==========================================================================
  // selection state machine
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= sers_pkg::ST_POR; // R1
    end else begin
      unique case (state_q)
        sers_pkg::ST_POR: begin
          // a host already holding cs low must release it first
          if (ready_q && cs_s) begin
            state_q <= sers_pkg::ST_STBY; // R1 R4
          end
        end
        sers_pkg::ST_STBY: begin
          if (fall) begin
            state_q <= sers_pkg::ST_OPC; // R4
          end
        end
        sers_pkg::ST_OPC: begin
          if (cs_s) begin
            state_q <= sers_pkg::ST_STBY; // R3 R12
          end else if (byte_evt) begin
            state_q <= sers_pkg::ST_DATA;
          end
        end
        sers_pkg::ST_DATA: begin
          if (cs_s) begin
            state_q <= sers_pkg::ST_STBY; // R3 R12
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // write enable latch and status write
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wel_q <= 1'b0; // R5
    end else if (state_q == sers_pkg::ST_OPC && byte_evt && !cs_s) begin
      if (sers_pkg::op_match(byte_q, sers_pkg::OP_WREN)) begin
        wel_q <= 1'b1;
      end else if (sers_pkg::op_match(byte_q, sers_pkg::OP_WRDI)) begin
        wel_q <= 1'b0;
      end
    end else if (nv_we_q) begin
      wel_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrsr_q <= 1'b0;
    end else if (cs_s) begin
      wrsr_q <= 1'b0; // R12
    end else if (state_q == sers_pkg::ST_OPC && byte_evt) begin
      wrsr_q <= wel_q && sers_pkg::op_match(byte_q, sers_pkg::OP_WRSR);
    end else if (byte_evt) begin
      wrsr_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nv_we_q    <= 1'b0;
      nv_wdata_q <= 3'h0;
    end else begin
      nv_we_q    <= wrsr_q && byte_evt && state_q == sers_pkg::ST_DATA && !cs_s;
      nv_wdata_q <= {byte_q[sers_pkg::STAT_PPE], byte_q[sers_pkg::STAT_BPH],
                     byte_q[sers_pkg::STAT_BPL]};
    end
  end

  sers_nvstore #(.AW(AW)) u_nv (
    .clk          (ref_clk),
    .rstn         (rstn),
    .factory_init (factory_init),
    .we           (nv_we_q),
    .wdata        (nv_wdata_q),
    .rd_addr      (arr_addr),
    .nv_bits      (nv_bits), // R8
    .rd_data      (arr_rdata)
  );

  // ==========================================================================
  // status and user outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      status_q     <= sers_pkg::STAT_RST;
      selected_q   <= 1'b0;
      opcode_q     <= 8'h00;
      opcode_stb_q <= 1'b0;
    end else begin
      status_q     <= {nv_bits[2], 3'h0, nv_bits[1:0], wel_q, 1'b0}; // R6 R11
      selected_q   <= state_q == sers_pkg::ST_OPC || state_q == sers_pkg::ST_DATA;
      opcode_stb_q <= state_q == sers_pkg::ST_OPC && byte_evt && !cs_s;
      if (state_q == sers_pkg::ST_OPC && byte_evt) begin
        opcode_q <= byte_q;
      end
    end
  end

  assign to_link = {state_q != sers_pkg::ST_POR, status_q};

  // ==========================================================================
  // link side, clocked by sck; cs high clears the bit, shift and output flops with no clock needed
  assign link_rst_n = rstn & ~cs_n; // R3 R10 R12
  assign bit_done   = bit_q == sers_pkg::BIT_LAST && !hold_q;
  assign rx_byte    = {sh_q, si};

  // status changes only between frames, so per-bit sync is settled by bit 8
  sers_sync #(.W(9), .INIT(9'h000)) u_link_sync (
    .clk   (sck),
    .rst_n (rstn),
    .d     (to_link),
    .q     (link_s)
  );

  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_q   <= sers_pkg::BIT_RST; // R12
      sh_q    <= 7'h00;
      first_q <= 1'b0;
      rd_q    <= 1'b0;
    end else if (!hold_q) begin
      sh_q  <= rx_byte[6:0];
      bit_q <= bit_q + 3'h1;
      if (bit_done && !first_q) begin
        first_q <= 1'b1;
        rd_q    <= link_s[8] && sers_pkg::op_match(rx_byte, sers_pkg::OP_RDSR); // R1
      end
    end
  end

  // not cleared by cs, so a late toggle is never faked by a frame reset
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      byte_q <= 8'h00;
      tog_q  <= 1'b0;
    end else if (bit_done && link_s[8]) begin
      byte_q <= rx_byte;
      tog_q  <= ~tog_q;
    end
  end

  always_ff @(negedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      hold_q   <= 1'b0; // R7
      so       <= 1'b0;
      so_oe    <= 1'b0; // R10
      loaded_q <= 1'b0;
      rot_q    <= 8'h00;
    end else begin
      hold_q <= ~hold_n;
      so_oe  <= rd_q && hold_n;
      if (rd_q && !loaded_q) begin
        loaded_q <= 1'b1;
        so       <= link_s[7];
        rot_q    <= {link_s[6:0], link_s[7]};
      end else if (loaded_q && hold_n) begin
        so    <= rot_q[7];
        rot_q <= {rot_q[6:0], rot_q[7]};
      end
    end
  end

  // ==========================================================================
  // checks
  property p_por_quiet;
    @(posedge ref_clk) disable iff (!rstn)
    !ready_q |-> !opcode_stb_q && !wel_q && state_q == sers_pkg::ST_POR;
  endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("active before ready"); // R1

  property p_pup_time;
    @(posedge ref_clk) disable iff (!rstn)
    $rose(ready_q) |-> $past(pup_cnt_q) == PUP_LAST;
  endproperty
  a_pup_time: assert property (p_pup_time) else $error("power-up wait wrong"); // R2

  property p_cs_reset;
    @(posedge ref_clk) disable iff (!rstn)
    (cs_s && state_q != sers_pkg::ST_POR) |=> state_q == sers_pkg::ST_STBY && !wrsr_q;
  endproperty
  a_cs_reset: assert property (p_cs_reset) else $error("cs reset missed"); // R3

  property p_need_fall;
    @(posedge ref_clk) disable iff (!rstn)
    (state_q != sers_pkg::ST_OPC ##1 state_q == sers_pkg::ST_OPC) |-> $past(fall);
  endproperty
  a_need_fall: assert property (p_need_fall) else $error("active without fall"); // R4

  property p_wel_set;
    @(posedge ref_clk) disable iff (!rstn)
    $rose(wel_q) |-> $past(byte_evt) && sers_pkg::op_match($past(byte_q), sers_pkg::OP_WREN);
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch set without enable"); // R5

  property p_stat_map;
    @(posedge ref_clk) disable iff (!rstn)
    ready_q |=> status_q == {$past(nv_bits[2]), 3'h0, $past(nv_bits[1:0]), $past(wel_q), 1'b0};
  endproperty
  a_stat_map: assert property (p_stat_map) else $error("status layout wrong"); // R6 R11

  property p_nv_keep;
    @(posedge ref_clk) disable iff (!rstn)
    ready_q && !nv_we_q && !factory_init |=> $stable(nv_bits);
  endproperty
  a_nv_keep: assert property (p_nv_keep) else $error("protection bits moved"); // R8

  property p_so_off;
    @(posedge ref_clk) disable iff (!rstn)
    cs_s |-> !so_oe;
  endproperty
  a_so_off: assert property (p_so_off) else $error("output on while deselected"); // R10

  property p_hold_clear;
    @(negedge sck) disable iff (!link_rst_n)
    hold_n |=> !hold_q && !(so_oe && !rd_q);
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("stuck paused"); // R7

  property p_frame_clr;
    @(posedge sck) disable iff (!rstn)
    cs_n |-> bit_q == sers_pkg::BIT_RST && !first_q;
  endproperty
  a_frame_clr: assert property (p_frame_clr) else $error("partial bits kept"); // R12

  c_active: cover property (@(posedge ref_clk) disable iff (!rstn)
    state_q == sers_pkg::ST_STBY ##1 state_q == sers_pkg::ST_OPC);
  c_rdsr: cover property (@(posedge sck) disable iff (!link_rst_n) $rose(rd_q));
  c_nv_write: cover property (@(posedge ref_clk) disable iff (!rstn) nv_we_q);

endmodule

// ==== testbench/sers_master.sv ====
// spi bus master model for the eeprom link, mode 0
module sers_master (
  input  wire logic lclk,
  input  wire logic so,
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // idle levels: sck stands still low, si never holds its last bit
  initial begin
    sck    = 1'b0;
    cs_n   = 1'b1;
    si     = 1'b0;
    hold_n = 1'b1;
  end

  always @(posedge lclk) begin
    if (cs_n) begin
      si <= ~si;
    end
  end

  // ==========================================================================
  // link tasks
  task automatic sel();
    @(posedge lclk);
    cs_n <= 1'b0;
  endtask

  // cs high time kept well above three core cycles
  task automatic desel();
    @(negedge lclk);
    sck <= 1'b0;
    @(posedge lclk);
    cs_n <= 1'b1;
    repeat (4) @(posedge lclk);
  endtask

  // si set with the fall, so taken just before the rise
  task automatic clk_bit(input logic b, output logic r);
    @(negedge lclk);
    sck <= 1'b0;
    si  <= b;
    @(posedge lclk);
    r = so;
    sck <= 1'b1;
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], r);
      rx[i] = r;
    end
  endtask

  task automatic nib(input logic [3:0] tx);
    logic r;
    for (int i = 3; i >= 0; i--) begin
      clk_bit(tx[i], r);
    end
    @(negedge lclk);
    sck <= 1'b0;
  endtask

  // high, low, high with sck still
  task automatic sw_reset();
    @(posedge lclk);
    cs_n <= 1'b1;
    repeat (4) @(posedge lclk);
    cs_n <= 1'b0;
    repeat (4) @(posedge lclk);
    cs_n <= 1'b1;
    repeat (4) @(posedge lclk);
  endtask

  task automatic pause(input logic v);
    @(negedge lclk);
    hold_n <= v;
  endtask
endmodule

// ==== testbench/sers_top_tb_top.sv ====
// self-checking bench for the eeprom power-up and reset block
module sers_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // signals
  localparam int unsigned PUP = 60;
  logic       ref_clk      = 1'b0;
  logic       lclk         = 1'b0;
  logic       rstn         = 1'b0;
  logic       factory_init = 1'b0;
  logic [3:0] arr_addr     = 4'h0;
  logic [7:0] stb_cnt      = 8'h00;
  logic       sck, cs_n, si, hold_n, so, so_oe, so_wire;
  logic       ready_q, selected_q, opcode_stb_q;
  logic [7:0] arr_rdata, status_q, opcode_q, rx, n0;
  int         err_total    = 0;
  int         num_checks   = 0;
  int         cyc          = 0;
  int         rel          = 0;

  initial forever #2 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #3 lclk = ~lclk;
  end

  // released so line shows the inverse of its last bit, never a stale value
  assign so_wire = so_oe ? so : ~so;

  sers_master i_sers_master (.lclk(lclk), .so(so_wire), .sck(sck), .cs_n(cs_n),
    .si(si), .hold_n(hold_n));

  sers_top #(.PUP_CYCLES(PUP), .CNT_W(16), .AW(4)) i_sers_top (.ref_clk(ref_clk),
    .rstn(rstn), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so),
    .so_oe(so_oe), .factory_init(factory_init), .arr_addr(arr_addr),
    .arr_rdata(arr_rdata), .ready_q(ready_q), .selected_q(selected_q),
    .status_q(status_q), .opcode_q(opcode_q), .opcode_stb_q(opcode_stb_q));

  // ==========================================================================
  // counters and helpers
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    rel <= rstn ? rel + 1 : 0;
    if (opcode_stb_q === 1'b1) begin
      stb_cnt <= stb_cnt + 8'h01;
    end
    if (cyc == 20000) begin
      err_total = err_total + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH at %0t: %s got %h", $time, m, g);
    end
  endtask

  task automatic chk1(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask

  task automatic pwr();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask

  task automatic wait_rel(input int n);
    while (rel < n) @(posedge ref_clk);
    #1;
  endtask

  task automatic op(input logic [7:0] b);
    logic [7:0] r;
    i_sers_master.sel();
    i_sers_master.xfer(b, r);
    i_sers_master.desel();
  endtask

  task automatic rdsr(output logic [7:0] v);
    logic [7:0] r;
    i_sers_master.sel();
    i_sers_master.xfer(sers_pkg::OP_RDSR, r);
    i_sers_master.xfer(8'h00, v);
    i_sers_master.desel();
    #1;
    chk1(so_oe, 1'b0, "so driven while deselected");
  endtask

  // bounded wait for the core to take n opcodes in total
  task automatic op_done(input logic [7:0] n);
    for (int i = 0; i < 40 && stb_cnt !== n; i++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    #1;
    chk8(stb_cnt, n, "opcode count");
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_power_up();
    pwr();
    @(posedge ref_clk);
    factory_init <= 1'b1;
    @(posedge ref_clk);
    factory_init <= 1'b0;
    n0 = stb_cnt;
    op(sers_pkg::OP_WREN);
    wait_rel(PUP - 2);
    chk1(ready_q, 1'b0, "ready too early");
    wait_rel(PUP + 2);
    chk1(ready_q, 1'b1, "ready too late");
    repeat (4) @(posedge ref_clk);
    #1;
    chk8(stb_cnt, n0, "early opcode taken");
    chk8(status_q, 8'h00, "status default");
    chk1(selected_q, 1'b0, "selected at power-up");
    rdsr(rx);
    chk8(rx, 8'h00, "status on link");
    for (int a = 0; a < 16; a++) begin
      arr_addr <= a[3:0];
      repeat (2) @(posedge ref_clk);
      #1;
      chk8(arr_rdata, 8'hff, "array byte");
    end
  endtask

  task automatic t_latch();
    n0 = stb_cnt;
    op(sers_pkg::OP_WREN);
    op_done(n0 + 8'h01);
    chk8(opcode_q, 8'h06, "opcode value");
    chk8(status_q, 8'h02, "latch set");
    rdsr(rx);
    chk8(rx, 8'h02, "latch on link");
    op(8'h0c);
    op_done(n0 + 8'h03);
    chk8(status_q, 8'h00, "latch clear");
    op(sers_pkg::OP_WREN);
    i_sers_master.sel();
    i_sers_master.xfer(sers_pkg::OP_WRSR, rx);
    i_sers_master.xfer(8'hff, rx);
    i_sers_master.desel();
    op_done(n0 + 8'h05);
    chk8(status_q, 8'h8c, "status write");
    rdsr(rx);
    chk8(rx, 8'h8c, "status write on link");
  endtask

  // partial bits then a clockless cs toggle must not shift the next opcode
  task automatic t_cs_reset();
    n0 = stb_cnt;
    i_sers_master.sel();
    i_sers_master.nib(4'hf);
    i_sers_master.sw_reset();
    op(sers_pkg::OP_WREN);
    op_done(n0 + 8'h01);
    chk8(opcode_q, 8'h06, "opcode after cs reset");
    chk8(status_q, 8'h8e, "latch after cs reset");
  endtask

  // power cycle while selected and paused, latch set before
  task automatic t_power_cycle();
    i_sers_master.sel();
    i_sers_master.pause(1'b0);
    pwr();
    wait_rel(PUP + 2);
    i_sers_master.pause(1'b1);
    repeat (4) @(posedge ref_clk);
    n0 = stb_cnt;
    i_sers_master.xfer(sers_pkg::OP_WREN, rx);
    i_sers_master.desel();
    repeat (6) @(posedge ref_clk);
    #1;
    chk8(stb_cnt, n0, "opcode without cs fall");
    chk8(status_q, 8'h8c, "bits after power cycle");
    rdsr(rx);
    chk8(rx, 8'h8c, "status read after power cycle");
    @(posedge ref_clk);
    factory_init <= 1'b1;
    @(posedge ref_clk);
    factory_init <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk8(status_q, 8'h00, "factory protection bits");
  endtask

  initial begin
    t_power_up();
    t_latch();
    t_cs_reset();
    t_power_cycle();
    conclude();
  end
endmodule
